// ---- logic/pdb_pkg.sv ----
`default_nettype none
// ***************************************************************
// Shared constants of the parallel display bus master.
// ***************************************************************
package pdb_pkg;

   // System clock period in nanoseconds (20 MHz).
   localparam int CLK_PERIOD_NS       = 50;

   // Strobe and panel reset timing minimums in nanoseconds.
   localparam int STORE_LOW_TIME_NS   = 50;
   localparam int STORE_HIGH_TIME_NS  = 50;
   localparam int STORE_CYCLE_TIME_NS = 100;
   localparam int FETCH_LOW_TIME_NS   = 150;
   localparam int FETCH_HIGH_TIME_NS  = 150;
   localparam int FETCH_CYCLE_TIME_NS = 300;
   localparam int DATA_SETUP_NS       = 25;
   localparam int INIT_PULSE_NS       = 10000;

   // Ceiling division to whole clock cycles, never below one.
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Cycle counts derived from the times above.
   localparam int STORE_LOW_CYC  = ns_to_cyc(STORE_LOW_TIME_NS);
   localparam int STORE_HIGH_CYC =
      (ns_to_cyc(STORE_CYCLE_TIME_NS) - STORE_LOW_CYC > ns_to_cyc(STORE_HIGH_TIME_NS)) ?
      ns_to_cyc(STORE_CYCLE_TIME_NS) - STORE_LOW_CYC : ns_to_cyc(STORE_HIGH_TIME_NS);
   localparam int SETUP_CYC      = ns_to_cyc(DATA_SETUP_NS);
   localparam int FETCH_LOW_CYC  = ns_to_cyc(FETCH_LOW_TIME_NS);
   localparam int FETCH_HIGH_CYC =
      (ns_to_cyc(FETCH_CYCLE_TIME_NS) - FETCH_LOW_CYC > ns_to_cyc(FETCH_HIGH_TIME_NS)) ?
      ns_to_cyc(FETCH_CYCLE_TIME_NS) - FETCH_LOW_CYC : ns_to_cyc(FETCH_HIGH_TIME_NS);
   localparam int INIT_PULSE_CYC = ns_to_cyc(INIT_PULSE_NS);

   // Bus operation codes: bit 1 is register select, bit 0 is read.
   typedef enum logic [1:0] {
      OP_STATUS_RD = 2'h1,
      OP_INDEX_WR  = 2'h0,
      OP_GRAPHICS_MEMORY_RD   = 2'h3,
      OP_DATA_WR   = 2'h2
   } op_e;

   // Width of the pixel bus.
   localparam int BUS_W = 16;

endpackage
`default_nettype wire

// ---- logic/pdb_timer_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Phase timer handshake between the sequencer and its timer.
// ***************************************************************
interface pdb_timer_if;
   logic        load;   // Start a new phase.
   logic [15:0] count;  // Phase length in cycles.
   logic        done;   // Phase has run its length.
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ---- logic/pdb_phase_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Down counter that times each bus phase.
// ***************************************************************
module pdb_phase_timer (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // Sequencer side.
   pdb_timer_if.tmr  tif
);
   logic [15:0] cnt_r;  // Cycles left in the phase.

   // Done when the count has reached zero; it never looks at load, so no loop forms.
   assign tif.done = (cnt_r == 16'h0000);

   // Load subtracts one so that a load of N yields done N cycles later.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= 16'h0000;
      end else if (tif.load) begin
         cnt_r <= tif.count - 16'h0001;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
endmodule // pdb_phase_timer
`default_nettype wire

// ---- logic/pdb_master.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Parallel display bus master.
// ***************************************************************
// Function
// - Status read: select low, register low, read low.
// - Index write: select low, register low, write low.
// - Memory read: select low, register high, read low.
// - Data write: select low, register high, write low.
// - One sixteen bit two way pixel bus.
// - Register select low index, high data.
// - Pulse panel reset low, then high.
// - Write strobe low only while writing data.
// - Read strobe low only while reading data.
// - Write low 50, high 50, cycle 100 ns.
// - Read low 150, high 150, cycle 300 ns.
// - All panel timing generated inside here.
// - Provide high voltage converter enable output.
// - Converter enable high on, low off.
module pdb_master #(
   parameter int INIT_CYC = pdb_pkg::INIT_PULSE_CYC  // Panel reset low length.
) (
   // Clock and reset.
   input  wire logic                       i_clk,
   input  wire logic                       i_arst_n,
   // Request side from the graphics engine.
   input  wire logic                       i_req_valid,
   output logic                            o_req_ready,
   input  wire logic [1:0]                 i_req_op,
   input  wire logic [pdb_pkg::BUS_W-1:0]  i_req_data,
   output logic                            o_rsp_valid,
   output logic [pdb_pkg::BUS_W-1:0]       o_rsp_data,
   // Converter control.
   input  wire logic                       i_hv_enable,
   // Panel pins.
   output logic                            o_cs_n,
   output logic                            o_register_select,
   output logic                            o_rd_n,
   output logic                            o_wr_n,
   output logic                            o_panel_init_pulse_n,
   output logic                            o_hv_converter_on,
   input  wire logic [pdb_pkg::BUS_W-1:0]  i_pixel_bus,
   output logic [pdb_pkg::BUS_W-1:0]       o_pixel_bus,
   output logic                            o_pixel_bus_oe
);

   // ************************************************************
   // State encoding.
   // ************************************************************
   typedef enum logic [6:0] {
      ST_INIT   = 7'h01,  // Panel reset held low.
      ST_IDLE   = 7'h02,  // Waiting for a request.
      ST_SETUP  = 7'h04,  // Write data and select settle.
      ST_WLOW   = 7'h08,  // Write strobe low.
      ST_RLOW   = 7'h10,  // Read strobe low.
      ST_RECOV  = 7'h20,  // Strobe high recovery.
      ST_WAKE   = 7'h40   // Panel recovers after reset.
   } state_e;

   state_e                    state_r;      // Current state.
   state_e                    state_nxt;    // Next state.
   logic                      is_read_r;    // Operation in flight is a read.
   logic                      rs_r;         // Register select level.
   logic                      cs_n_r;       // Chip select level.
   logic                      rd_n_r;       // Read strobe level.
   logic                      wr_n_r;       // Write strobe level.
   logic                      init_n_r;     // Panel reset level.
   logic                      hv_r;         // Converter enable level.
   logic                      oe_r;         // Bus drive enable.
   logic [pdb_pkg::BUS_W-1:0] wdata_r;      // Word to drive.
   logic [pdb_pkg::BUS_W-1:0] rdata_r;      // Captured read word.
   logic                      rsp_r;        // Read answer pulse.
   logic [pdb_pkg::BUS_W-1:0] bus_s1_r;     // Pixel bus first stage.
   logic [pdb_pkg::BUS_W-1:0] bus_s2_r;     // Pixel bus second stage.
   logic                      take;         // Request accepted this cycle.
   logic                      req_rd;       // Requested op reads.
   logic                      req_rs;       // Requested register select.
   logic                      rd_cap;       // Capture point for read data.
   logic                      rd_end_r;     // Read strobe ended last cycle.
   logic                      boot_r;       // First cycle after reset.

   pdb_timer_if tif ();

   // ************************************************************
   // Phase timer.
   // ************************************************************
   pdb_phase_timer u_timer (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .tif      (tif)
   );

   // Decode the operation code into select and direction.
   assign req_rd      = i_req_op[0];
   assign req_rs      = i_req_op[1];
   assign o_req_ready = (state_r == ST_IDLE) && tif.done;
   assign take        = o_req_ready && i_req_valid;
   // Capture one cycle after the strobe ends, so the synchroniser hands over the pin
   // as sampled mid-strobe and a slow panel still has time to answer.
   assign rd_cap      = rd_end_r;

   // Next-state selection; timer loads when a phase begins.
   always_comb begin
      state_nxt = state_r;
      tif.load  = 1'b0;
      tif.count = 16'h0001;
      unique case (state_r)
         ST_INIT: begin
            if (boot_r) begin
               // First cycle after reset: time the panel reset pulse.
               tif.load  = 1'b1;
               tif.count = 16'(INIT_CYC);
            end else if (tif.done) begin
               state_nxt = ST_WAKE;
               tif.load  = 1'b1;
               tif.count = 16'(INIT_CYC);
            end
         end
         ST_WAKE: begin
            if (tif.done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (take) begin
               state_nxt = req_rd ? ST_RLOW : ST_SETUP;
               tif.load  = 1'b1;
               // Read: no setup phase, strobe goes low with the select; write first waits SETUP_CYC.
               tif.count = req_rd ? 16'(pdb_pkg::FETCH_LOW_CYC)
                                  : 16'(pdb_pkg::SETUP_CYC);
            end
         end
         ST_SETUP: begin
            if (tif.done) begin
               state_nxt = ST_WLOW;
               tif.load  = 1'b1;
               tif.count = 16'(pdb_pkg::STORE_LOW_CYC);
            end
         end
         ST_WLOW: begin
            if (tif.done) begin
               state_nxt = ST_RECOV;
               tif.load  = 1'b1;
               tif.count = 16'(pdb_pkg::STORE_HIGH_CYC);
            end
         end
         ST_RLOW: begin
            if (tif.done) begin
               state_nxt = ST_RECOV;
               tif.load  = 1'b1;
               tif.count = 16'(pdb_pkg::FETCH_HIGH_CYC);
            end
         end
         ST_RECOV: begin
            if (tif.done) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   // State register; boot_r marks the first cycle so the init phase loads the timer.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_INIT;
         boot_r  <= 1'b1;
      end else begin
         state_r <= state_nxt;
         boot_r  <= 1'b0;
      end
   end

   // Panel pins, all from flip-flops; timing made here without outside help.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cs_n_r    <= 1'b1;
         rs_r      <= 1'b0;
         rd_n_r    <= 1'b1;
         wr_n_r    <= 1'b1;
         oe_r      <= 1'b0;
         is_read_r <= 1'b0;
         wdata_r   <= 16'h0000;
      end else if (take) begin
         cs_n_r    <= 1'b0;
         rs_r      <= req_rs;
         is_read_r <= req_rd;
         rd_n_r    <= !req_rd;
         oe_r      <= !req_rd;
         wdata_r   <= i_req_data;
      end else if (state_r == ST_SETUP && tif.done) begin
         wr_n_r    <= 1'b0;
      end else if ((state_r == ST_WLOW || state_r == ST_RLOW) && tif.done) begin
         wr_n_r    <= 1'b1;
         rd_n_r    <= 1'b1;
      end else if (state_r == ST_RECOV && tif.done) begin
         cs_n_r    <= 1'b1;
         oe_r      <= 1'b0;
      end
   end

   // Panel reset pulse: low through the init phase, then high.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         init_n_r <= 1'b0;
      end else if (state_r == ST_INIT && tif.done && !boot_r) begin
         init_n_r <= 1'b1;
      end
   end

   // Converter enable follows the engine's request; high means on.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hv_r <= 1'b0;
      end else begin
         hv_r <= i_hv_enable;
      end
   end

   // Pixel bus input synchroniser; the panel drives it only during read strobe.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bus_s1_r <= 16'h0000;
         bus_s2_r <= 16'h0000;
      end else begin
         bus_s1_r <= i_pixel_bus;
         bus_s2_r <= bus_s1_r;
      end
   end

   // Read word captured one cycle after the strobe-low phase ends.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r  <= 16'h0000;
         rsp_r    <= 1'b0;
         rd_end_r <= 1'b0;
      end else begin
         rd_end_r <= (state_r == ST_RLOW) && tif.done;
         rsp_r    <= rd_cap;
         if (rd_cap) begin
            rdata_r <= bus_s2_r;
         end
      end
   end

   // Output connections.
   assign o_cs_n               = cs_n_r;
   assign o_register_select    = rs_r;
   assign o_rd_n               = rd_n_r;
   assign o_wr_n               = wr_n_r;
   assign o_panel_init_pulse_n = init_n_r;
   assign o_hv_converter_on    = hv_r;
   assign o_pixel_bus          = wdata_r;
   assign o_pixel_bus_oe       = oe_r && !is_read_r;
   assign o_rsp_valid          = rsp_r;
   assign o_rsp_data           = rdata_r;

endmodule // pdb_master
`default_nettype wire

// ---- verif/pdb_master_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******
// Pin protocol checks on the display bus master.
// ******
module pdb_master_asserts #(
   parameter int INIT_CYC = 4  // Panel reset low length.
) (
   // Clock, reset, request side and pixel bus.
   input wire logic                      i_clk, i_arst_n, i_req_valid, o_req_ready,
   input wire logic [1:0]                i_req_op,
   input wire logic [pdb_pkg::BUS_W-1:0] i_req_data, o_rsp_data, i_pixel_bus, o_pixel_bus,
   // Response valid, panel pins and converter.
   input wire logic                      o_rsp_valid, i_hv_enable, o_cs_n, o_register_select,
   input wire logic                      o_rd_n, o_wr_n, o_panel_init_pulse_n,
   input wire logic                      o_hv_converter_on, o_pixel_bus_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic [15:0] init_cnt_r;  // Cycles the panel reset has been low.
   // Counts the panel reset pulse length since the last reset.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) init_cnt_r <= 16'h0;
      else if (!o_panel_init_pulse_n) init_cnt_r <= init_cnt_r + 16'h1;
   end
   property p_strobe_sel;
      (!o_rd_n || !o_wr_n) |-> !o_cs_n && (o_rd_n != o_wr_n); endproperty
   a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
   property p_take_sel;
      (i_req_valid && o_req_ready) |=> !o_cs_n && o_register_select == $past(i_req_op[1]);
   endproperty
   a_take_sel: assert property (p_take_sel) else $error("register select wrong");
   property p_wr_oe; !o_wr_n |-> o_pixel_bus_oe && $past(o_pixel_bus_oe); endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("write without driven data");
   property p_wr_data; !o_wr_n |-> $stable(o_pixel_bus); endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data moved in strobe");
   property p_rd_release; !o_rd_n |-> !o_pixel_bus_oe && !$past(o_pixel_bus_oe); endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus driven in read");
   property p_wr_pulse; $fell(o_wr_n) |=> o_wr_n [*2]; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse timing");
   property p_rd_pulse; $fell(o_rd_n) |-> !o_rd_n [*3] ##1 o_rd_n [*3]; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse timing");
   property p_rsp; $fell(o_rd_n) |-> ##4 o_rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("read answer late");
   property p_rsp_src; o_rsp_valid |-> !$past(o_rd_n, 2) && $past(o_rd_n); endproperty
   a_rsp_src: assert property (p_rsp_src) else $error("answer without read");
   property p_init; $rose(o_panel_init_pulse_n) |-> init_cnt_r >= INIT_CYC; endproperty
   a_init: assert property (p_init) else $error("panel reset too short");
   property p_init_idle; !o_panel_init_pulse_n |-> o_cs_n && !o_req_ready; endproperty
   a_init_idle: assert property (p_init_idle) else $error("bus busy in init");
   property p_hv;
      (i_hv_enable != o_hv_converter_on) |=> o_hv_converter_on == $past(i_hv_enable);
   endproperty
   a_hv: assert property (p_hv) else $error("converter enable wrong");
   // Main scenarios are reached.
   c_wr: cover property ($fell(o_wr_n));
   c_rd: cover property (o_rsp_valid);
   c_init: cover property ($rose(o_panel_init_pulse_n));
endmodule // pdb_master_asserts
bind pdb_master pdb_master_asserts #(.INIT_CYC(INIT_CYC)) pdb_master_asserts_i (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
   .i_req_op(i_req_op), .i_req_data(i_req_data), .o_rsp_data(o_rsp_data),
   .i_pixel_bus(i_pixel_bus), .o_pixel_bus(o_pixel_bus), .o_rsp_valid(o_rsp_valid),
   .i_hv_enable(i_hv_enable), .o_cs_n(o_cs_n), .o_register_select(o_register_select),
   .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_panel_init_pulse_n(o_panel_init_pulse_n),
   .o_hv_converter_on(o_hv_converter_on), .o_pixel_bus_oe(o_pixel_bus_oe));
`default_nettype wire

// ---- verif/pdb_panel_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******
// Behavioural panel controller with index, status and memory.
// ******
module pdb_panel_model #(
   parameter logic [15:0] STATUS_VAL = 16'h3C5A  // Status word, arbitrary.
) (
   // Panel pins from the master.
   input wire logic        i_clk, i_cs_n, i_register_select, i_rd_n, i_wr_n, i_init_n,
   input wire logic        i_slow,  // Answer one cycle into the strobe.
   input wire logic [15:0] i_bus,
   output logic [15:0]     o_bus,
   output logic            o_oe
);
   logic [15:0] mem [16];          // Small graphics memory.
   logic [3:0]  index_r;           // Current index register.
   logic [15:0] last_r = 16'h0;    // Last bus value, inverted when idle.
   logic        old_r = 1'b0;      // Strobe was already low last cycle.
   logic        fetch;             // Panel selected for a read.
   logic [15:0] word;              // Word the panel answers with.
   assign fetch = !i_cs_n && !i_rd_n;
   assign word  = i_register_select ? mem[index_r] : STATUS_VAL;
   assign o_oe  = fetch;
   // An idle or not yet valid bus toggles, so a stale value never passes.
   assign o_bus = (fetch && (!i_slow || old_r)) ? word : ~last_r;
   // Writes land in the index or the memory; reset clears the index.
   always_ff @(posedge i_clk) begin
      last_r <= o_bus;
      old_r  <= fetch;
      if (!i_init_n) index_r <= 4'h0;
      else if (!i_cs_n && !i_wr_n) begin
         if (i_register_select) mem[index_r] <= i_bus;
         else index_r <= i_bus[3:0];
      end
   end
endmodule // pdb_panel_model
`default_nettype wire

// ---- verif/parallel_display_bus_master_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******
// Self-checking bench of the display bus master.
// ******
module parallel_display_bus_master_tb_top;
   logic clk, arst_n, req_valid, req_ready, rsp_valid, hv_en, cs_n, rs, rd_n, wr_n;
   logic init_n, hv_on, m_oe, p_oe, slow;  // Pins, drivers and model speed.
   logic [1:0]  req_op;                    // Requested operation.
   logic [15:0] req_data, rsp_data, bus_in, m_bus, p_bus, q;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   // Clock of 50 ns.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   assign bus_in = m_oe ? m_bus : p_bus;  // Wire level from both drivers.
   pdb_master #(.INIT_CYC(4)) pdb_master_i (.i_clk(clk), .i_arst_n(arst_n),
      .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_op(req_op),
      .i_req_data(req_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
      .i_hv_enable(hv_en), .o_cs_n(cs_n), .o_register_select(rs), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_panel_init_pulse_n(init_n), .o_hv_converter_on(hv_on),
      .i_pixel_bus(bus_in), .o_pixel_bus(m_bus), .o_pixel_bus_oe(m_oe));
   pdb_panel_model pdb_panel_model_i (.i_clk(clk), .i_cs_n(cs_n), .i_register_select(rs),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_init_n(init_n), .i_slow(slow), .i_bus(bus_in),
      .o_bus(p_bus), .o_oe(p_oe));
   // Compares one value and reports a mismatch.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Runs one request; a read returns its word.
   task automatic xfer(input logic [1:0] op, input logic [15:0] d, output logic [15:0] r);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op    <= op;
      req_data  <= d;
      for (n = 0; n < 500; n++) begin
         @(negedge clk);
         if (req_ready === 1'b1) break;
      end
      chk(16'(n < 500), 16'h1);
      @(posedge clk);
      req_valid <= 1'b0;
      if (op[0]) begin
         for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) break;
         end
         chk({15'h0, rsp_valid}, 16'h1);
         r = rsp_data;
      end
   endtask
   // Release reset and time the panel reset pulse.
   task automatic t_init;
      int n;
      @(negedge clk);
      chk({10'h0, cs_n, rd_n, wr_n, init_n, m_oe, hv_on}, 16'h38);
      @(posedge clk);
      arst_n <= 1'b1;
      for (n = 0; n < 100 && init_n !== 1'b1; n++) @(negedge clk);
      chk(16'(n >= 4), 16'h1);
      chk({15'h0, init_n}, 16'h1);
   endtask
   // Back-to-back writes, then read back memory and status.
   task automatic t_wr_rd;
      xfer(pdb_pkg::OP_INDEX_WR, 16'h0005, q);
      xfer(pdb_pkg::OP_DATA_WR, 16'hA5A5, q);
      xfer(pdb_pkg::OP_INDEX_WR, 16'h0006, q);
      xfer(pdb_pkg::OP_DATA_WR, 16'h5A5A, q);
      xfer(pdb_pkg::OP_INDEX_WR, 16'h0005, q);
      xfer(pdb_pkg::OP_GRAPHICS_MEMORY_RD, 16'h0, q);
      chk(q, 16'hA5A5);
      xfer(pdb_pkg::OP_INDEX_WR, 16'h0006, q);
      xfer(pdb_pkg::OP_GRAPHICS_MEMORY_RD, 16'h0, q);
      chk(q, 16'h5A5A);
      xfer(pdb_pkg::OP_STATUS_RD, 16'h0, q);
      chk(q, 16'h3C5A);
   endtask
   // A slow panel answers late in the strobe.
   task automatic t_slow;
      slow <= 1'b1;
      xfer(pdb_pkg::OP_GRAPHICS_MEMORY_RD, 16'h0, q);
      chk(q, 16'h5A5A);
      slow <= 1'b0;
   endtask
   // The converter enable follows its request both ways.
   task automatic t_hv;
      @(posedge clk);
      hv_en <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk({15'h0, hv_on}, 16'h1);
      @(posedge clk);
      hv_en <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk({15'h0, hv_on}, 16'h0);
   endtask
   // Reset in mid-read, then a request waiting through init.
   task automatic t_midrst;
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op    <= pdb_pkg::OP_GRAPHICS_MEMORY_RD;
      for (n = 0; n < 50 && rd_n !== 1'b0; n++) @(negedge clk);
      @(posedge clk);
      arst_n    <= 1'b0;
      req_valid <= 1'b0;
      @(negedge clk);
      chk({12'h0, cs_n, rd_n, init_n, m_oe}, 16'hC);
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      xfer(pdb_pkg::OP_STATUS_RD, 16'h0, q);
      chk(q, 16'h3C5A);
   endtask
   // Both sides never drive the pixel bus at once.
   always @(negedge clk) begin
      if (m_oe === 1'b1 && p_oe === 1'b1) chk(16'h1, 16'h0);
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   // Main sequence.
   initial begin
      arst_n = 1'b0;
      req_valid = 1'b0;
      req_op = 2'h0;
      req_data = 16'h0;
      hv_en = 1'b0;
      slow = 1'b0;
      repeat (10) @(posedge clk);
      t_init();
      t_wr_rd();
      t_slow();
      t_hv();
      t_midrst();
      results();
   end
endmodule // parallel_display_bus_master_tb_top
`default_nettype wire
